// File: hdl/sram_port_defines.svh
`ifndef SRAM_PORT_DEFINES_SVH
`define SRAM_PORT_DEFINES_SVH

// ----------------------------------------------------------------
// Data path geometry (wide configuration)
// ----------------------------------------------------------------
`define DATA_W      36
`define LANES       4
`define LANE_W      9
`define ADDR_W      19
`define MEM_WORDS   (1 << `ADDR_W)
`define BURST_LEN   2

// ----------------------------------------------------------------
// Write buffer
// ----------------------------------------------------------------
`define FIFO_DEPTH  32
`define WR_ROOM     4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_SYS_NS  25
`define LINK_CLK_NS 200
`define RD_LAT_HALF 5
`define RD_LAT_CYC  ((`RD_LAT_HALF * `LINK_CLK_NS) / (2 * `CLK_SYS_NS))

`endif

// File: hdl/sram_port_pkg.sv
`include "sram_port_defines.svh"

package sram_port_pkg;

    typedef logic [`DATA_W-1:0] dq_t;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`LANES-1:0]  lane_t;

    // One buffered write word on its way to the arrays
    typedef struct packed {
        addr_t addr;
        logic  sel;
        dq_t   data;
        lane_t lane_n;
    } wr_ent_s;

    // Every pin that crosses into the system clock domain
    typedef struct packed {
        logic  k;
        logic  k_n;
        logic  ld_n;
        logic  rw;
        addr_t addr;
        dq_t   dq;
        lane_t lane_n;
    } pins_s;

    typedef enum logic [2:0] {
        W_IDLE  = 3'b001,
        W_WORD0 = 3'b010,
        W_WORD1 = 3'b100
    } wr_state_e;

endpackage : sram_port_pkg

// File: hdl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser; the first stage feeds only the second
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule : pin_sync

`default_nettype wire

// File: hdl/wr_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module wr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rstn,
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [WIDTH-1:0]         in_data,
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic      [WIDTH-1:0]         out_data,
    output logic      [$clog2(DEPTH):0]   level
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready  = (level != DEPTH[AW:0]);
    assign out_valid = (level != '0);
    assign out_data  = store[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointers and fill level
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop)  rd_ptr <= rd_ptr + 1'b1;
            level <= level + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clk_sys) begin
        if (push) store[wr_ptr] <= in_data;
    end

    fifo_bound_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (level == DEPTH[AW:0]) |-> !in_ready ##1 (level != '0))
        else $error("fifo full flag or level wrong");

endmodule : wr_fifo

`default_nettype wire

// File: hdl/ddr_burst2_sram_port.sv
// Operation
// - Write data captured on true-clock rise and on complementary-clock rise.
// - Read data launched one word per true and complementary clock rise.
// - Data outputs float by themselves whenever no read is being driven.
// - Data bus is 18 bits narrow or 36 bits wide; wide built here.
// - Low load strobe on true-clock rise starts a bus cycle.
// - Every access moves exactly two words for its one address.
// - Lanes with enable high are ignored and keep stored contents.
// - Each enable governs one 9-bit lane, lane 0 lowest.
// - Lane enables sampled on the same edge as their data word.
// - One shared address bus sampled on the command's true-clock rise.
// - Two internal arrays; each address selects a pair of words.
// - Direction high means read, low means write, while strobe low.
// - Accesses start only on true-clock rises, never complementary.
// - Output-valid flag marks read data, aligned with echo strobes.
`timescale 1ns/1ps
`default_nettype none

`include "sram_port_defines.svh"

module ddr_burst2_sram_port
    import sram_port_pkg::*;
(
    input  wire logic  clk_sys,
    input  wire logic  rstn,
    input  wire logic  link_k,
    input  wire logic  link_k_n,
    input  wire logic  load_strobe_n,
    input  wire logic  rw_dir,
    input  wire addr_t addr,
    input  wire dq_t   dq_i,
    input  wire lane_t byte_lane_enable_n,
    output logic [`DATA_W-1:0] dq_o,
    output logic       dq_oe,
    output logic       echo_strobe,
    output logic       echo_strobe_n,
    output logic       output_valid_flag
);

    localparam int RD_LAT_LO = `RD_LAT_CYC - 1;
    localparam int RD_LAT_HI = `RD_LAT_CYC + 3;
    localparam int WR_GAP_HI = 12;

    // ------------------------------------------------------------
    // Pin synchronisation and link clock edges
    // ------------------------------------------------------------

    pins_s pin_raw;
    pins_s pin_s;
    logic  k_prev;
    logic  kn_prev;
    logic  k_rise;
    logic  kn_rise;

    // All pins share one synchroniser so data stays coherent with the clock
    assign pin_raw = {link_k, link_k_n, load_strobe_n, rw_dir, addr,
                      dq_i, byte_lane_enable_n};

    pin_sync #(
        .WIDTH ($bits(pins_s))
    ) u_sync (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .d       (pin_raw),
        .q       (pin_s)
    );

    // Previous link clock levels for edge detection
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            k_prev  <= 1'b0;
            kn_prev <= 1'b0;
        end else begin
            k_prev  <= pin_s.k;
            kn_prev <= pin_s.k_n;
        end
    end

    assign k_rise  = pin_s.k & ~k_prev;
    assign kn_rise = pin_s.k_n & ~kn_prev;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------

    logic                  cmd_valid;
    logic                  cmd_rd;
    logic                  cmd_wr;
    logic                  wr_room;
    logic [$clog2(`FIFO_DEPTH):0] fifo_level;

    // Commands only on the true clock; complementary edges never start one
    assign cmd_valid = k_rise & ~pin_s.ld_n;
    assign cmd_rd    = cmd_valid & pin_s.rw;
    // Refusing a write without room for two bursts keeps the buffer honest
    assign wr_room   = (fifo_level <= ($clog2(`FIFO_DEPTH)+1)'(`FIFO_DEPTH - `WR_ROOM));
    assign cmd_wr    = cmd_valid & ~pin_s.rw & wr_room;

    cmd_edge_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (cmd_rd || cmd_wr) |-> k_rise && !kn_rise && !pin_s.ld_n)
        else $error("access started off a true clock rise");

    // ------------------------------------------------------------
    // Write sequencer
    // ------------------------------------------------------------

    wr_state_e wr_state;
    addr_t     wr_addr;
    addr_t     wr_addr_nx;
    logic      wr_next;
    logic      push0;
    logic      push1;
    wr_ent_s   push_ent;

    // Word 0 on the next true rise, word 1 on the complementary rise after
    assign push0 = k_rise & (wr_state == W_WORD0);
    assign push1 = kn_rise & (wr_state == W_WORD1);

    // Lane enables ride with the word they qualify
    always_comb begin
        push_ent.addr   = wr_addr;
        push_ent.sel    = push1;
        push_ent.data   = pin_s.dq;
        push_ent.lane_n = pin_s.lane_n;
    end

    // Burst state; a second command may load while a burst is running
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wr_state   <= W_IDLE;
            wr_addr    <= '0;
            wr_addr_nx <= '0;
            wr_next    <= 1'b0;
        end else begin
            case (wr_state)
                W_IDLE: begin
                    if (cmd_wr) begin
                        wr_state <= W_WORD0;
                        wr_addr  <= pin_s.addr;
                    end
                end
                W_WORD0: begin
                    if (k_rise) begin
                        wr_state <= W_WORD1;
                    end
                    if (cmd_wr) begin
                        wr_next    <= 1'b1;
                        wr_addr_nx <= pin_s.addr;
                    end
                end
                W_WORD1: begin
                    if (cmd_wr) begin
                        wr_next    <= 1'b1;
                        wr_addr_nx <= pin_s.addr;
                    end else if (kn_rise) begin
                        wr_next <= 1'b0;
                    end
                    // Exactly two words per burst, then next or idle
                    if (kn_rise) begin
                        if (wr_next) begin
                            wr_state <= W_WORD0;
                            wr_addr  <= wr_addr_nx;
                        end else begin
                            wr_state <= W_IDLE;
                        end
                    end
                end
                default: begin
                    wr_state <= W_IDLE;
                end
            endcase
        end
    end

    wr_addr_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (cmd_wr && wr_state == W_IDLE) |=> wr_addr == $past(pin_s.addr))
        else $error("write address not taken from command edge");

    wr_two_words_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (cmd_wr && wr_state == W_IDLE)
            |-> ##[1:WR_GAP_HI] push0 ##[1:WR_GAP_HI] push1)
        else $error("write burst did not take two words");

    wr_word1_edge_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        push1 |-> kn_rise && $past(wr_state) != W_IDLE)
        else $error("second write word off the complementary rise");

    // ------------------------------------------------------------
    // Write buffer between the link and the arrays
    // ------------------------------------------------------------

    wr_ent_s drain_ent;
    logic    drain_valid;
    logic    drain_ready;
    logic    fetch;
    logic    pop;

    wr_fifo #(
        .WIDTH ($bits(wr_ent_s)),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .in_valid  (push0 | push1),
        .in_ready  (),
        .in_data   (push_ent),
        .out_valid (drain_valid),
        .out_ready (drain_ready),
        .out_data  (drain_ent),
        .level     (fifo_level)
    );

    // Array read for a burst wins the cycle; the drain waits one clock
    assign drain_ready = ~fetch;
    assign pop         = drain_valid & drain_ready;

    // ------------------------------------------------------------
    // Storage arrays
    // ------------------------------------------------------------

    // Two arrays so one address yields both words of a burst
    dq_t mem0 [0:`MEM_WORDS-1];
    dq_t mem1 [0:`MEM_WORDS-1];

    // Lane-masked write; masked lanes leave old bits in place
    always_ff @(posedge clk_sys) begin
        if (pop) begin
            for (int i = 0; i < `LANES; i++) begin
                if (!drain_ent.lane_n[i]) begin
                    if (drain_ent.sel) begin
                        mem1[drain_ent.addr][i*`LANE_W +: `LANE_W] <=
                            drain_ent.data[i*`LANE_W +: `LANE_W];
                    end else begin
                        mem0[drain_ent.addr][i*`LANE_W +: `LANE_W] <=
                            drain_ent.data[i*`LANE_W +: `LANE_W];
                    end
                end
            end
        end
    end

    // Helper copy of lane 0 before a masked write, for checking only
    addr_t                chk_addr;
    logic [`LANE_W-1:0]   chk_lane0;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            chk_addr  <= '0;
            chk_lane0 <= '0;
        end else begin
            chk_addr  <= drain_ent.addr;
            chk_lane0 <= mem0[drain_ent.addr][`LANE_W-1:0];
        end
    end

    lane_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (pop && !drain_ent.sel && drain_ent.lane_n[0])
            |=> mem0[chk_addr][`LANE_W-1:0] == chk_lane0)
        else $error("masked lane was overwritten");

    // ------------------------------------------------------------
    // Read pipeline
    // ------------------------------------------------------------

    logic [2:0] rd_pipe;
    addr_t      rd_addr0;
    addr_t      rd_addr1;
    dq_t        hold0;
    dq_t        hold1;

    // Fetch as late as possible so earlier write bursts have drained
    assign fetch = k_rise & rd_pipe[1];

    // Pipeline counts true-clock rises since each read command
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rd_pipe  <= '0;
            rd_addr0 <= '0;
            rd_addr1 <= '0;
        end else if (k_rise) begin
            rd_pipe  <= {rd_pipe[1:0], cmd_rd};
            rd_addr0 <= pin_s.addr;
            rd_addr1 <= rd_addr0;
        end
    end

    // Both words of the pair come out of the two arrays together
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            hold0 <= '0;
            hold1 <= '0;
        end else if (fetch) begin
            hold0 <= mem0[rd_addr1];
            hold1 <= mem1[rd_addr1];
        end
    end

    // ------------------------------------------------------------
    // Output drive, valid flag and echo strobes
    // ------------------------------------------------------------

    // Word 0 on complementary rise, word 1 on the next true rise
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            dq_o              <= '0;
            dq_oe             <= 1'b0;
            output_valid_flag <= 1'b0;
        end else if (kn_rise) begin
            if (rd_pipe[2]) begin
                dq_o              <= hold0;
                dq_oe             <= 1'b1;
                output_valid_flag <= 1'b1;
            end else begin
                dq_oe             <= 1'b0;
                output_valid_flag <= 1'b0;
            end
        end else if (k_rise && rd_pipe[2]) begin
            dq_o              <= hold1;
            dq_oe             <= 1'b1;
            output_valid_flag <= 1'b1;
        end
    end

    // Echoes follow the link clocks with the same delay as the data
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            echo_strobe   <= 1'b0;
            echo_strobe_n <= 1'b0;
        end else begin
            echo_strobe   <= pin_s.k;
            echo_strobe_n <= pin_s.k_n;
        end
    end

    rd_latency_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        cmd_rd |-> ##[RD_LAT_LO:RD_LAT_HI] (dq_oe && output_valid_flag))
        else $error("read data late against command");

    oe_start_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(dq_oe) |-> $past(kn_rise) && $past(rd_pipe[2]))
        else $error("output drive began off complementary rise");

    oe_release_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(dq_oe) |-> $past(kn_rise) && !$past(rd_pipe[2]))
        else $error("output released at wrong time");

    valid_echo_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $changed(output_valid_flag)
            |-> ($changed(echo_strobe) || $changed(echo_strobe_n))
                && output_valid_flag == dq_oe)
        else $error("valid flag not aligned with echo strobes");

endmodule : ddr_burst2_sram_port

`default_nettype wire

// File: dv/ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

// Memory controller on the far side of the pins; link clock runs free
module ctrl_model
    import sram_port_pkg::*;
(
    input  wire logic clk_sys,
    output var logic  link_k,
    output logic      link_k_n,
    output var logic  load_strobe_n,
    output var logic  rw_dir,
    output var addr_t addr,
    output var dq_t   dq_drv,
    output var logic  dq_drv_oe,
    output var lane_t byte_lane_enable_n
);
    logic  wr_pend;
    dq_t   pd0;
    dq_t   pd1;
    lane_t pl0;
    lane_t pl1;

    // Free running link clock with an odd phase offset to the system clock
    initial begin
        link_k = 1'b0;
        #37;
        forever #100 link_k = ~link_k;
    end
    assign link_k_n = ~link_k;

    initial begin
        load_strobe_n      = 1'b1;
        rw_dir             = 1'b0;
        addr               = '0;
        dq_drv             = '0;
        dq_drv_oe          = 1'b0;
        byte_lane_enable_n = '1;
        wr_pend            = 1'b0;
    end

    // Drive a word with its lanes, or release the bus showing inverted lines
    task automatic put(input logic en, input dq_t d, input lane_t l);
        if (en) begin
            dq_drv             = d;
            byte_lane_enable_n = l;
            dq_drv_oe          = 1'b1;
        end else begin
            dq_drv             = ~dq_drv;
            byte_lane_enable_n = ~byte_lane_enable_n;
            dq_drv_oe          = 1'b0;
        end
    endtask : put

    // One link cycle; changes land four system cycles after a link edge,
    // which keeps every input stable for three cycles past the edge
    task automatic cycle(input logic ld, input logic rw, input addr_t a,
                         input dq_t d0, input lane_t l0, input dq_t d1,
                         input lane_t l1, input logic ld_kn, output realtime t);
        @(posedge link_k_n);
        repeat (4) @(negedge clk_sys);
        load_strobe_n = ld;
        rw_dir        = rw;
        addr          = a;
        put(wr_pend, pd0, pl0);
        @(posedge link_k);
        t = $realtime;
        repeat (4) @(negedge clk_sys);
        load_strobe_n = ld_kn;
        put(wr_pend, pd1, pl1);
        wr_pend = !ld && !rw;
        pd0     = d0;
        pl0     = l0;
        pd1     = d1;
        pl1     = l1;
    endtask : cycle
endmodule : ctrl_model

`default_nettype wire

// File: dv/ddr_burst2_sram_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ddr_burst2_sram_port_tb
    import sram_port_pkg::*;
;
    typedef struct { dq_t d; bit first; realtime t; } note_s;

    logic    clk_sys;
    logic    rstn;
    logic    link_k;
    logic    link_k_n;
    logic    load_strobe_n;
    logic    rw_dir;
    addr_t   addr;
    dq_t     dq_drv;
    logic    dq_drv_oe;
    dq_t     dq_i;
    lane_t   byte_lane_enable_n;
    dq_t     dq_o;
    logic    dq_oe;
    logic    echo_strobe;
    logic    echo_strobe_n;
    logic    output_valid_flag;
    int      mismatches;
    int      cmp_count;
    int      cycles;
    integer  seed;
    note_s   exp_q[$];
    dq_t     ref0[addr_t];
    dq_t     ref1[addr_t];
    addr_t   al[8];
    logic    pe;
    logic    pe_n;
    note_s   e;
    real     lat;
    bit      last_rd;

    initial clk_sys = 1'b0;
    always #12.5 clk_sys = ~clk_sys;

    // Bus level: the block wins only while it drives; model shows inverted lines
    assign dq_i = dq_oe ? dq_o : dq_drv;

    ctrl_model u_ctrl_model (
        .clk_sys            (clk_sys),
        .link_k             (link_k),
        .link_k_n           (link_k_n),
        .load_strobe_n      (load_strobe_n),
        .rw_dir             (rw_dir),
        .addr               (addr),
        .dq_drv             (dq_drv),
        .dq_drv_oe          (dq_drv_oe),
        .byte_lane_enable_n (byte_lane_enable_n)
    );

    ddr_burst2_sram_port u_ddr_burst2_sram_port (
        .clk_sys            (clk_sys),
        .rstn               (rstn),
        .link_k             (link_k),
        .link_k_n           (link_k_n),
        .load_strobe_n      (load_strobe_n),
        .rw_dir             (rw_dir),
        .addr               (addr),
        .dq_i               (dq_i),
        .byte_lane_enable_n (byte_lane_enable_n),
        .dq_o               (dq_o),
        .dq_oe              (dq_oe),
        .echo_strobe        (echo_strobe),
        .echo_strobe_n      (echo_strobe_n),
        .output_valid_flag  (output_valid_flag)
    );

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // Expected lane merge: only enabled 9-bit lanes take new data
    function automatic dq_t merge(input dq_t old, input dq_t nw, input lane_t ln);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (!ln[i]) merge[9*i +: 9] = nw[9*i +: 9];
        end
    endfunction : merge

    function automatic dq_t rnd_dq();
        rnd_dq = dq_t'({$random(seed), $random(seed)});
    endfunction : rnd_dq

    task automatic wr(input addr_t a, input lane_t l0, input lane_t l1);
        dq_t     d0;
        dq_t     d1;
        realtime t;
        // The shared bus needs two quiet link cycles after a read burst
        if (last_rd) repeat (2) idle(1'b1);
        last_rd = 1'b0;
        d0 = rnd_dq();
        d1 = rnd_dq();
        ref0[a] = ref0.exists(a) ? merge(ref0[a], d0, l0) : d0;
        ref1[a] = ref1.exists(a) ? merge(ref1[a], d1, l1) : d1;
        u_ctrl_model.cycle(1'b0, 1'b0, a, d0, l0, d1, l1, 1'b1, t);
    endtask : wr

    task automatic rd(input addr_t a);
        note_s   n0;
        note_s   n1;
        realtime t;
        n0.d     = ref0[a];
        n1.d     = ref1[a];
        n0.first = 1'b1;
        n1.first = 1'b0;
        u_ctrl_model.cycle(1'b0, 1'b1, a, rnd_dq(), '1, rnd_dq(), '1, 1'b1, t);
        n0.t = t;
        n1.t = t;
        exp_q.push_back(n0);
        exp_q.push_back(n1);
        last_rd = 1'b1;
    endtask : rd

    task automatic idle(input logic ld_kn);
        realtime t;
        u_ctrl_model.cycle(1'b1, 1'b1, addr_t'($random(seed)), '0, '1, '0, '1, ld_kn, t);
    endtask : idle

    // Wait for outstanding words under a bound, then the bus must float
    task automatic drain(input string name);
        // One quiet link cycle lets the model release the last write word
        idle(1'b1);
        for (int i = 0; i < 80 && exp_q.size() > 0; i++) @(negedge clk_sys);
        repeat (8) @(negedge clk_sys);
        check("words_left", exp_q.size(), 0);
        check("oe_idle", dq_oe, 1'b0);
        $display("test %s done", name);
    endtask : drain

    // ------------------------------------------------------------
    // Read word monitor
    // ------------------------------------------------------------
    // Each word is judged where the echo strobe that carries it rises
    always @(negedge clk_sys) begin
        if (rstn === 1'b1) begin
            if (dq_oe === 1'b1 && dq_drv_oe === 1'b1) check("bus_clash", 1'b1, 1'b0);
            if (output_valid_flag === 1'b1 && ((echo_strobe_n && !pe_n) || (echo_strobe && !pe))) begin
                check("oe_with_valid", dq_oe, 1'b1);
                if (exp_q.size() == 0) begin
                    check("extra_word", 1'b1, 1'b0);
                end else begin
                    e = exp_q.pop_front();
                    check("read_word", dq_o, e.d);
                    if (e.first) begin
                        check("word0_edge", echo_strobe_n, 1'b1);
                        lat = ($realtime - e.t) / 25.0;
                        check("latency", lat >= 22.0 && lat <= 27.0, 1'b1);
                    end
                end
            end
        end
        pe   <= echo_strobe;
        pe_n <= echo_strobe_n;
    end

    // Hang guard: the whole run needs about 850 system cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 8000) begin
            mismatches++;
            $display("unexpected timeout: expected done, seen still running");
            final_report();
        end
    end

    initial begin
        mismatches = 0;
        cmp_count  = 0;
        cycles     = 0;
        seed       = 32'h399bf1e7;
        rstn       = 1'b0;
        pe         = 1'b0;
        pe_n       = 1'b0;
        repeat (2) @(negedge clk_sys);
        check("oe_reset", dq_oe, 1'b0);
        check("valid_reset", output_valid_flag, 1'b0);
        check("echo_reset", {echo_strobe, echo_strobe_n}, 2'b00);
        rstn = 1'b1;
        repeat (4) @(negedge clk_sys);
        // Full writes back to back, boundary addresses included, then reads
        for (int i = 0; i < 8; i++) begin
            al[i] = (i == 0) ? '0 : (i == 7) ? '1 : addr_t'($random(seed));
            wr(al[i], '0, '0);
        end
        for (int i = 0; i < 8; i++) rd(al[i]);
        drain("full_write_read");
        // Every lane pattern, different per word, read straight after
        for (int m = 0; m < 16; m++) begin
            wr(al[m % 8], lane_t'(m), ~lane_t'(m));
            rd(al[m % 8]);
        end
        drain("lane_masks");
        // Read before write must see old data, read after sees new
        rd(al[3]);
        wr(al[3], '0, 4'h5);
        rd(al[3]);
        drain("read_write_order");
        // Strobe low only across the complementary edge starts nothing
        idle(1'b0);
        idle(1'b0);
        idle(1'b1);
        rd(al[7]);
        drain("complementary_strobe");
        final_report();
    end
endmodule : ddr_burst2_sram_port_tb

`default_nettype wire
